// ### hdl/rtca_pkg.sv
package rtca_pkg;
  // Bus address and direction
  localparam logic [6:0] SLAVE_ADDR = 7'h51;
  localparam logic DIR_READ = 1'b1;
  // Register offsets
  localparam logic [7:0] OFS_CTRL2 = 8'h01;
  localparam logic [7:0] OFS_SEC = 8'h02;
  localparam logic [7:0] OFS_MIN = 8'h03;
  localparam logic [7:0] OFS_HOUR = 8'h04;
  localparam logic [7:0] OFS_DATE = 8'h05;
  localparam logic [7:0] OFS_WDAY = 8'h06;
  localparam logic [7:0] OFS_AMIN = 8'h09;
  localparam logic [7:0] OFS_AHOUR = 8'h0a;
  localparam logic [7:0] OFS_ADATE = 8'h0b;
  localparam logic [7:0] OFS_AWDAY = 8'h0c;
  // Field positions
  localparam int AF_BIT = 3;
  localparam int AIE_BIT = 1;
  localparam int AE_BIT = 7;
  localparam int OSF_BIT = 7;
  // Significant bits of the minute, hour, date and weekday registers
  localparam logic [7:0] MASK_MIN = 8'h7f;
  localparam logic [7:0] MASK_HOUR = 8'h3f;
  localparam logic [7:0] MASK_DATE = 8'h3f;
  localparam logic [7:0] MASK_WDAY = 8'h07;
  localparam logic [7:0] SEC_RST = 8'h80;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Receiver states
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_WRITE, ST_READ, ST_RACK, ST_WAIT}
    rtca_state_e;
endpackage : rtca_pkg

// ### hdl/rtca_slave.sv
`timescale 1ns/100ps
`default_nettype none
module rtca_slave
  import rtca_pkg::*;
#(
  parameter int BUF_DEPTH = 2
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Time tick from the counting chain, one cycle per increment
  input wire logic time_tick,
  // Alarm outputs and write refusal pulse
  output logic alarm_irq_n,
  output logic alarm_flag,
  output logic xfer_fail
);

  // Pin synchronisers: two flops each, plus a third delay flop for edge detection
  logic scl_s1_r, scl_s2_r, scl_d_r, sda_s1_r, sda_s2_r, sda_d_r;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_s1_r <= scl_in;
      scl_s2_r <= scl_s1_r;
      scl_d_r <= scl_s2_r;
      sda_s1_r <= sda_in;
      sda_s2_r <= sda_s1_r;
      sda_d_r <= sda_s2_r;
    end
  end

  // Line events; SDA moving under high SCL is always a condition
  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_s2_r & ~scl_d_r;
  assign scl_fall = ~scl_s2_r & scl_d_r;
  assign start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  assign stop_det = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

  // Register file
  logic [7:0] sec_r, min_r, hour_r, date_r, wday_r;
  logic [7:0] amin_r, ahour_r, adate_r, awday_r;
  logic aie_r, af_r;
  logic [7:0] ptr_r;

  // Read mux; unmapped offsets read zero
  function automatic logic [7:0] reg_read(input logic [7:0] ofs);
    logic [7:0] v;
    v = ZERO8;
    unique case (ofs)
      OFS_CTRL2:
      begin
        v[AF_BIT] = af_r;
        v[AIE_BIT] = aie_r;
      end
      OFS_SEC: v = sec_r;
      OFS_MIN: v = min_r;
      OFS_HOUR: v = hour_r;
      OFS_DATE: v = date_r;
      OFS_WDAY: v = wday_r;
      OFS_AMIN: v = amin_r;
      OFS_AHOUR: v = ahour_r;
      OFS_ADATE: v = adate_r;
      OFS_AWDAY: v = awday_r;
      default: v = ZERO8;
    endcase
    return v;
  endfunction : reg_read

  // One alarm field: true when disabled or matching
  function automatic logic field_ok(input logic [7:0] alm, input logic [7:0] cur,
                                    input logic [7:0] mask);
    return alm[AE_BIT] | ((alm & mask) == (cur & mask));
  endfunction : field_ok

  // Bus state machine
  rtca_state_e state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic rw_r, first_r, ack_sent_r;
  logic wr_stb;
  logic [7:0] wr_data;

  // Two-entry buffer between receiver and register file
  logic [7:0] buf_q [BUF_DEPTH];
  logic [$clog2(BUF_DEPTH):0] buf_cnt_r;
  logic buf_rd_ptr_r, buf_wr_ptr_r;
  logic buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
  assign buf_in_ready = (buf_cnt_r != BUF_DEPTH[$clog2(BUF_DEPTH):0]);
  assign buf_out_valid = (buf_cnt_r != '0);
  assign buf_out_ready = 1'b1;
  assign wr_stb = buf_out_valid & buf_out_ready;
  assign wr_data = buf_q[buf_rd_ptr_r];

  logic rx_done;
  assign rx_done = scl_fall && bit_cnt_r == BITS_PER_BYTE;
  // Data byte complete; a full buffer holds back the acknowledge
  assign buf_in_valid = (state_r == ST_WRITE) && rx_done && !first_r;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      buf_cnt_r <= '0;
      buf_rd_ptr_r <= 1'b0;
      buf_wr_ptr_r <= 1'b0;
    end
    else
    begin
      if (buf_in_valid && buf_in_ready)
      begin
        buf_q[buf_wr_ptr_r] <= shift_r;
        buf_wr_ptr_r <= ~buf_wr_ptr_r;
      end
      if (wr_stb)
        buf_rd_ptr_r <= ~buf_rd_ptr_r;
      buf_cnt_r <= buf_cnt_r + ((buf_in_valid && buf_in_ready) ? 1'b1 : 1'b0)
                   - (wr_stb ? 1'b1 : 1'b0);
    end
  end

  // Write side pointer, a separate copy that follows queued writes
  logic [7:0] wptr_r;

  // Byte at the read pointer; a process, so register writes re-evaluate it
  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = reg_read(ptr_r);
  end

  // Protocol sequencer
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_r <= ST_IDLE;
      bit_cnt_r <= '0;
      shift_r <= ZERO8;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      ack_sent_r <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      xfer_fail <= 1'b0;
      ptr_r <= ZERO8;
    end
    else if (start_det)
    begin
      state_r <= ST_ADDR;
      bit_cnt_r <= '0;
      sda_oe <= 1'b0;
    end
    else if (stop_det)
    begin
      state_r <= ST_IDLE;
      sda_oe <= 1'b0;
    end
    else
    begin
      xfer_fail <= 1'b0;
      if (scl_rise && (state_r == ST_ADDR || state_r == ST_WRITE))
      begin
        shift_r <= {shift_r[6:0], sda_s2_r};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      unique case (state_r)
        ST_IDLE: sda_oe <= 1'b0;
        ST_WAIT: sda_oe <= 1'b0;
        ST_ADDR:
          if (rx_done)
          begin
            if (shift_r[7:1] == SLAVE_ADDR)
            begin
              rw_r <= shift_r[0];
              first_r <= ~shift_r[0];
              sda_out <= 1'b0;
              sda_oe <= 1'b1;
              state_r <= ST_ACK;
            end
            else
              state_r <= ST_IDLE;
          end
        ST_WRITE:
          if (rx_done)
          begin
            bit_cnt_r <= '0;
            if (first_r)
            begin
              ptr_r <= shift_r;
              first_r <= 1'b0;
              sda_out <= 1'b0;
              sda_oe <= 1'b1;
              state_r <= ST_ACK;
            end
            else if (buf_in_ready)
            begin
              ptr_r <= ptr_r + 8'h01;
              sda_out <= 1'b0;
              sda_oe <= 1'b1;
              state_r <= ST_ACK;
            end
            else
            begin
              xfer_fail <= 1'b1;
              state_r <= ST_WAIT;
            end
          end
        ST_ACK:
          if (scl_fall)
          begin
            bit_cnt_r <= '0;
            if (rw_r == DIR_READ)
            begin
              sda_out <= 1'b0;
              shift_r <= {rd_byte[6:0], 1'b0};
              ptr_r <= ptr_r + 8'h01;
              sda_oe <= ~rd_byte[7];
              bit_cnt_r <= 4'h1;
              state_r <= ST_READ;
            end
            else
            begin
              sda_oe <= 1'b0;
              state_r <= ST_WRITE;
            end
          end
        ST_READ:
          if (scl_fall)
          begin
            if (bit_cnt_r == BITS_PER_BYTE)
            begin
              sda_oe <= 1'b0;
              state_r <= ST_RACK;
            end
            else
            begin
              sda_oe <= ~shift_r[7];
              shift_r <= {shift_r[6:0], 1'b0};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
        ST_RACK:
          if (scl_rise)
          begin
            if (sda_s2_r)
              state_r <= ST_WAIT;
            else
              state_r <= ST_ACK;
          end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Write pointer tracks ptr_r for queued data bytes
  always_ff @(posedge clk)
  begin
    if (reset)
      wptr_r <= ZERO8;
    else if (state_r == ST_WRITE && rx_done && first_r)
      wptr_r <= shift_r;
    else if (wr_stb)
      wptr_r <= wptr_r + 8'h01;
  end

  // Time, alarm and control registers, written by host; ticks come from outside
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sec_r <= SEC_RST;
      min_r <= ZERO8;
      hour_r <= ZERO8;
      date_r <= ZERO8;
      wday_r <= ZERO8;
      amin_r <= ZERO8;
      ahour_r <= ZERO8;
      adate_r <= ZERO8;
      awday_r <= ZERO8;
      aie_r <= 1'b0;
    end
    else if (wr_stb)
    begin
      unique case (wptr_r)
        OFS_CTRL2: aie_r <= wr_data[AIE_BIT];
        OFS_SEC: sec_r <= wr_data;
        OFS_MIN: min_r <= wr_data & MASK_MIN;
        OFS_HOUR: hour_r <= wr_data & MASK_HOUR;
        OFS_DATE: date_r <= wr_data & MASK_DATE;
        OFS_WDAY: wday_r <= wr_data & MASK_WDAY;
        OFS_AMIN: amin_r <= wr_data;
        OFS_AHOUR: ahour_r <= wr_data;
        OFS_ADATE: adate_r <= wr_data;
        OFS_AWDAY: awday_r <= wr_data;
        default: ;
      endcase
    end
  end

  // Alarm compare; a new match only counts on a time tick
  logic match, match_d_r, af_clr;
  assign match = field_ok(amin_r, min_r, MASK_MIN) & field_ok(ahour_r, hour_r, MASK_HOUR)
               & field_ok(adate_r, date_r, MASK_DATE) & field_ok(awday_r, wday_r, MASK_WDAY);
  assign af_clr = wr_stb && wptr_r == OFS_CTRL2 && !wr_data[AF_BIT];

  // Flag set wins over clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      af_r <= 1'b0;
      match_d_r <= 1'b0;
    end
    else
    begin
      if (time_tick)
        match_d_r <= match;
      if (time_tick && match && !match_d_r)
        af_r <= 1'b1;
      else if (af_clr)
        af_r <= 1'b0;
    end
  end

  // Outputs straight from flops
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      alarm_irq_n <= 1'b1;
      alarm_flag <= 1'b0;
    end
    else
    begin
      alarm_irq_n <= ~(af_r & aie_r);
      alarm_flag <= af_r;
    end
  end

endmodule : rtca_slave
`default_nettype wire

// ### dv/rtca_slave_props.sv
`timescale 1ns/100ps
`default_nettype none
module rtca_slave_chk
  import rtca_pkg::*;
#(
  parameter int BUF_DEPTH = 2
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Alarm side
  input wire logic time_tick,
  input wire logic alarm_irq_n,
  input wire logic alarm_flag,
  input wire logic xfer_fail
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Reset must leave the bus released and the alarm quiet
  chk_reset_quiet: assert property (disable iff (1'b0)
    reset |=> !sda_oe && alarm_irq_n && !alarm_flag) else $error("not quiet after reset");
  // Open-drain only: the pin is never driven high
  chk_drive_low: assert property (sda_oe |-> !sda_out) else $error("sda driven high");
  // Device starts driving only inside a settled clock-low phase
  chk_drive_start: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in, 2))
    else $error("sda drive began with scl high");
  // While the clock is high the data line must hold, else it reads as a condition
  chk_sda_hold: assert property (scl_in && $past(scl_in, 3) |-> $stable(sda_oe))
    else $error("sda moved while scl high");
  // Flag rises only two cycles after a time step
  chk_flag_tick: assert property ($rose(alarm_flag) |-> $past(time_tick, 2))
    else $error("flag rose without a tick");
  // Without bus clocking the flag cannot clear by itself
  chk_flag_sticky: assert property (alarm_flag && scl_in [*8] |=> alarm_flag)
    else $error("flag cleared without a write");
  // Interrupt is gated by the flag
  chk_irq_gate: assert property (!alarm_irq_n |-> alarm_flag)
    else $error("interrupt without flag");
  // Refusal is a single pulse, never an acknowledge
  chk_fail_pulse: assert property (xfer_fail |=> !xfer_fail [*2])
    else $error("fail pulse too long");
endmodule : rtca_slave_chk
bind rtca_slave rtca_slave_chk #(.BUF_DEPTH(BUF_DEPTH)) chk_u (.clk(clk), .reset(reset),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .time_tick(time_tick), .alarm_irq_n(alarm_irq_n), .alarm_flag(alarm_flag),
  .xfer_fail(xfer_fail));
`default_nettype wire

// ### dv/rtca_host_mdl.sv
`timescale 1ns/100ps
`default_nettype none
module rtca_host_mdl
#(
  parameter int QTR = 50
)
(
  // Bus wire seen and pulls applied
  input wire logic sda_line,
  output logic scl_pull,
  output logic sda_pull
);
  // Released lines rest high through the pull-ups
  initial
  begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  // One bit: data changes while clock low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    sda_pull = ~b;
    #QTR scl_pull = 1'b0;
    #QTR r = sda_line;
    #QTR scl_pull = 1'b1;
    #QTR;
  endtask : bit_io
  // Same waveform serves start and repeated start
  task automatic start;
    sda_pull = 1'b0;
    #QTR scl_pull = 1'b0;
    #QTR sda_pull = 1'b1;
    #QTR scl_pull = 1'b1;
    #QTR;
  endtask : start
  task automatic stop;
    sda_pull = 1'b1;
    #QTR scl_pull = 1'b0;
    #QTR sda_pull = 1'b0;
    #QTR;
  endtask : stop
  // Whole byte MSB first, then the acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
    output logic ack_out);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack_out);
  endtask : xfer
endmodule : rtca_host_mdl
`default_nettype wire

// ### dv/tb_rtca_slave.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin check_count++; if ((got) !== (exp)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module tb_rtca_slave
  import rtca_pkg::*;
;
  logic clk, reset, time_tick, sda_out, sda_oe, alarm_irq_n, alarm_flag, xfer_fail;
  logic scl_pull, sda_pull, sda_w, scl_w;
  int miscompares = 0;
  int check_count = 0;
  logic fail_seen = 1'b0;
  // Wired-AND of both open-drain parties
  assign sda_w = ~((sda_oe & ~sda_out) | sda_pull);
  assign scl_w = ~scl_pull;
  rtca_slave dut_u (.clk(clk), .reset(reset), .scl_in(scl_w), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .time_tick(time_tick),
    .alarm_irq_n(alarm_irq_n), .alarm_flag(alarm_flag), .xfer_fail(xfer_fail));
  // Quarter of the 200 ns bus clock period, a multiple of the 25 ns clock
  rtca_host_mdl #(.QTR(50)) mdl (.sda_line(sda_w), .scl_pull(scl_pull), .sda_pull(sda_pull));
  // No scenario fills the buffer, so any refusal pulse is an error
  always @(posedge clk)
  begin
    if (xfer_fail)
      fail_seen <= 1'b1;
  end
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  // Byte that the device must acknowledge
  task automatic tx_byte(input logic [7:0] b);
    logic [7:0] rx;
    logic a;
    mdl.xfer(b, 1'b1, rx, a);
    `CHK("ack", 1'b0, a)
  endtask : tx_byte
  task automatic wr_reg(input logic [7:0] p, input logic [7:0] d);
    mdl.start();
    tx_byte(8'ha2);
    tx_byte(p);
    tx_byte(d);
    mdl.stop();
  endtask : wr_reg
  task automatic tick;
    @(posedge clk) #2 time_tick = 1'b1;
    @(posedge clk) #2 time_tick = 1'b0;
    repeat (3) @(posedge clk);
    #2;
  endtask : tick
  // Mid-run reset returns the bus side and the alarm interrupt to rest
  task automatic t_reset;
    @(posedge clk) #2 reset = 1'b1;
    repeat (2) @(posedge clk);
    #2 reset = 1'b0;
    @(posedge clk) #2;
    `CHK("reset irq", 1'b1, alarm_irq_n)
    `CHK("reset oe", 1'b0, sda_oe)
    `CHK("no refusal", 1'b0, fail_seen)
    $display("test reset done");
  endtask : t_reset
  task automatic t_burst;
    logic [7:0] v [4] = '{8'h81, 8'h92, 8'ha3, 8'h04};
    logic [7:0] rx;
    logic a;
    mdl.start();
    tx_byte(8'ha2);
    tx_byte(OFS_SEC);
    mdl.start();
    tx_byte(8'ha3);
    mdl.xfer(8'hff, 1'b1, rx, a);
    mdl.stop();
    `CHK("seconds", SEC_RST, rx)
    wr_reg(OFS_AMIN, v[0]);
    mdl.start();
    tx_byte(8'ha2);
    tx_byte(OFS_AHOUR);
    for (int i = 1; i < 4; i++) tx_byte(v[i]);
    mdl.stop();
    mdl.start();
    tx_byte(8'ha2);
    tx_byte(OFS_AMIN);
    mdl.start();
    tx_byte(8'ha3);
    for (int i = 0; i < 4; i++)
    begin
      mdl.xfer(8'hff, i == 3, rx, a);
      `CHK("burst", v[i], rx)
    end
    `CHK("release", 1'b0, sda_oe)
    mdl.stop();
    $display("test burst done");
  endtask : t_burst
  task automatic t_addr;
    logic [7:0] rx;
    logic a;
    mdl.start();
    mdl.xfer(8'ha4, 1'b1, rx, a);
    `CHK("foreign ack", 1'b1, a)
    mdl.xfer(8'h00, 1'b1, rx, a);
    `CHK("silent", 1'b1, a)
    mdl.stop();
    $display("test addr done");
  endtask : t_addr
  task automatic t_alarm;
    wr_reg(OFS_MIN, 8'h30);
    wr_reg(OFS_HOUR, 8'h12);
    wr_reg(OFS_AMIN, 8'h30);
    wr_reg(OFS_AHOUR, 8'h85);
    wr_reg(OFS_ADATE, 8'h80);
    wr_reg(OFS_AWDAY, 8'h80);
    wr_reg(OFS_CTRL2, 8'h02);
    tick();
    `CHK("flag", 1'b1, alarm_flag)
    `CHK("irq", 1'b0, alarm_irq_n)
    tick();
    wr_reg(OFS_CTRL2, 8'h08);
    `CHK("flag kept", 1'b1, alarm_flag)
    `CHK("irq off", 1'b1, alarm_irq_n)
    wr_reg(OFS_CTRL2, 8'h02);
    `CHK("flag clr", 1'b0, alarm_flag)
    tick();
    `CHK("persist", 1'b0, alarm_flag)
    wr_reg(OFS_MIN, 8'h31);
    tick();
    wr_reg(OFS_MIN, 8'h30);
    wr_reg(OFS_AHOUR, 8'h05);
    tick();
    `CHK("hour gate", 1'b0, alarm_flag)
    wr_reg(OFS_AHOUR, 8'h85);
    tick();
    `CHK("rematch", 1'b1, alarm_flag)
    $display("test alarm done");
  endtask : t_alarm
  // Hang guard well beyond the expected run time
  initial
  begin
    #400000;
    miscompares++;
    test_done();
  end
  initial
  begin
    reset = 1'b1;
    time_tick = 1'b0;
    repeat (20) @(posedge clk);
    #2 reset = 1'b0;
    @(posedge clk) #2;
    `CHK("idle oe", 1'b0, sda_oe)
    `CHK("idle irq", 1'b1, alarm_irq_n)
    t_burst();
    t_addr();
    t_alarm();
    t_reset();
    test_done();
  end
endmodule : tb_rtca_slave
`default_nettype wire
